// ===== logic/scm_cmd_target.sv
/*
 * Two-wire target with the configuration command interpreter.
 * Assumes an external pull-up on the data line, a bus clock well below
 * the system clock, and i_rst asserted at power-on.
 */
// Behaviour
// R01: host sends entry code within 10 ms
// R02: entry accepted only inside power-on window
// R03: codes 00-1F read a config word
// R04: codes 40-5F write word, 12 ms busy
// R05: code 80 leaves command mode, starts measuring
// R06: code B0 returns the revision word
// R07: entry answered by status byte 0x81
// R08: host uses default address 0x28
// R09: word 1C holds the address, default 0x28
// R10: host writes new address via 0x5C
// R11: host re-reads word 1C to verify
// R12: power cycle also leaves command mode
// R13: host may slow clock below 100kHz
// R14: read commands carry zero data word
// R15: answers via later read, within 100 us
// R16: status byte packs status, diagnostic, acknowledge
// R17: old address holds until command mode ends
`timescale 1ns/1ps
`include "scm_map.svh"
module scm_cmd_target #(
    parameter int          WIN_CYC  = `SCM_WIN_MS * (`SCM_CLK_HZ / 1000),
    parameter int          WR_CYC   = `SCM_WR_MS * (`SCM_CLK_HZ / 1000),
    // value is arbitrary
    parameter logic [15:0] REVISION = 16'h0001
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_o,
    output logic            o_sda_oe,
    output logic            o_cmd_mode,
    output logic            o_window_open,
    output logic            o_measure_start,
    output logic [6:0]      o_bus_addr
);
    localparam int RESP_CYC = `SCM_RESP_US * (`SCM_CLK_HZ / 1000000);
    localparam int LW = WIN_CYC > WR_CYC ? WIN_CYC : WR_CYC;
    // counters must also hold the response time
    localparam int TW = $clog2((LW > RESP_CYC ? LW : RESP_CYC) + 1);
    localparam logic [15:0] ADDR_DEF = `SCM_ADDR_DEFAULT;

    function automatic logic [3:0] gray2bin(input logic [3:0] g);
        gray2bin = {g[3], ^g[3:2], ^g[3:1], ^g[3:0]};
    endfunction

    function automatic logic [3:0] bin2gray(input logic [3:0] b);
        bin2gray = b ^ {1'b0, b[3:1]};
    endfunction

    function automatic logic [7:0] pack_status(input logic [1:0] st,
                                               input logic [3:0] dg,
                                               input logic [1:0] ak);
        pack_status = {st, dg, ak};
    endfunction

    // link side: every bus clock rise stores the data bit in a ring
    logic [3:0]  wgray_q;
    logic [3:0]  wgray_d;
    logic [15:0] ring_q;
    logic [15:0] ring_d;

    always_comb begin
        wgray_d = bin2gray(gray2bin(wgray_q) + 4'h1);
        ring_d = ring_q;
        ring_d[gray2bin(wgray_q)] = i_sda;
    end

    // bus clock idles between frames, so reset cannot wait for its edges
    always_ff @(posedge i_scl or posedge i_rst) begin
        if (i_rst) begin
            wgray_q <= 4'h0;
            ring_q <= 16'h0000;
        end else begin
            wgray_q <= wgray_d;
            ring_q <= ring_d;
        end
    end

    // system side synchronisers
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic [3:0] gp1_q;
    logic [3:0] gp2_q;
    logic       scl_p_q;
    logic       sda_p_q;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            gp1_q <= 4'h0;
            gp2_q <= 4'h0;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], i_scl};
            sda_s_q <= {sda_s_q[0], i_sda};
            gp1_q <= wgray_q;
            gp2_q <= gp1_q;
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end

    scm_pkg::scm_phase_t phase_q, phase_d;
    logic [3:0]  bitcnt_q, bitcnt_d;
    logic [7:0]  byte_q, byte_d;
    logic [1:0]  bidx_q, bidx_d;
    logic [1:0]  rdidx_q, rdidx_d;
    logic [3:0]  rptr_q, rptr_d;
    logic        ack_q, ack_d;
    logic        rw_q, rw_d;
    logic        drive_q, drive_d;
    logic [7:0]  cmd_q, cmd_d;
    logic [15:0] dat_q, dat_d;
    logic        cmd_mode_q, cmd_mode_d;
    logic [TW-1:0] win_cnt_q, win_cnt_d;
    logic        win_open_q, win_open_d;
    logic        busy_q, busy_d;
    logic [TW-1:0] busy_cnt_q, busy_cnt_d;
    logic [1:0]  resp_ack_q, resp_ack_d;
    logic [7:0]  stat_snap_q, stat_snap_d;
    logic [15:0] rdata_q, rdata_d;
    logic [6:0]  active_addr_q, active_addr_d;
    logic        measure_q, measure_d;
    logic        sda_lo_q;
    logic [15:0] mem_q [32];
    logic        mem_we;
    logic [15:0] mem_rd;
    logic        start, stop, fall, have, bit_in, zero;
    logic [7:0]  full, stat_now, txb;
    logic        do_enter, do_read, do_write, do_exit, do_rev;

    always_comb begin
        start = scl_s_q[1] & sda_p_q & ~sda_s_q[1];
        stop = scl_s_q[1] & ~sda_p_q & sda_s_q[1];
        fall = scl_p_q & ~scl_s_q[1];
        have = rptr_q != gray2bin(gp2_q);
        // entry behind the synced pointer is settled in the link domain
        bit_in = ring_q[rptr_q];
        full = {byte_q[6:0], bit_in};
        mem_rd = mem_q[cmd_q[4:0]];
        // R16: status byte fields
        stat_now = pack_status(cmd_mode_q ? `SCM_STAT_CMD : `SCM_STAT_NORM,
                               4'h0, busy_q ? `SCM_ACK_BUSY : resp_ack_q);
        case (rdidx_q)
            2'h0:    txb = stat_snap_q;
            2'h1:    txb = rdata_q[15:8];
            2'h2:    txb = rdata_q[7:0];
            default: txb = `SCM_FILL_BYTE;
        endcase
        phase_d = phase_q;
        bitcnt_d = bitcnt_q;
        byte_d = byte_q;
        bidx_d = bidx_q;
        rdidx_d = rdidx_q;
        rptr_d = have ? rptr_q + 4'h1 : rptr_q;
        ack_d = ack_q;
        rw_d = rw_q;
        drive_d = drive_q;
        cmd_d = cmd_q;
        dat_d = dat_q;
        stat_snap_d = stat_snap_q;
        do_enter = 1'b0;
        do_read = 1'b0;
        do_write = 1'b0;
        do_exit = 1'b0;
        do_rev = 1'b0;
        zero = dat_q == 16'h0000;
        if (start) begin
            phase_d = scm_pkg::SCM_ADDR;
            bitcnt_d = 4'h0;
            bidx_d = 2'h0;
            ack_d = 1'b0;
            drive_d = 1'b0;
            rptr_d = gray2bin(gp2_q);
        end else if (stop) begin
            phase_d = scm_pkg::SCM_IDLE;
            drive_d = 1'b0;
            // R15: command runs after its frame, answer by later read
            if (phase_q == scm_pkg::SCM_WR && bidx_q == 2'h3 && !busy_q) begin
                if (!cmd_mode_q) begin
                    // R02: entry only inside window
                    do_enter = cmd_q == `SCM_CMD_ENTER && zero && win_open_q;
                end else if (cmd_q[7:5] == `SCM_GRP_READ) begin
                    // R14: read needs zero data word
                    do_read = zero;
                end else if (cmd_q[7:5] == `SCM_GRP_WRITE) begin
                    do_write = 1'b1;
                end else begin
                    do_exit = cmd_q == `SCM_CMD_EXIT && zero;
                    do_rev = cmd_q == `SCM_CMD_REV && zero;
                end
            end
        end else if (have && phase_q != scm_pkg::SCM_IDLE) begin
            bitcnt_d = bitcnt_q + 4'h1;
            byte_d = full;
            if (bitcnt_q == 4'h7) begin
                case (phase_q)
                    scm_pkg::SCM_ADDR: begin
                        // R08: answer only at the active address
                        if (full[7:1] == active_addr_q) begin
                            ack_d = 1'b1;
                            rw_d = full[0];
                            stat_snap_d = stat_now;
                        end else begin
                            phase_d = scm_pkg::SCM_IDLE;
                        end
                    end
                    scm_pkg::SCM_WR: begin
                        ack_d = bidx_q != 2'h3;
                        case (bidx_q)
                            2'h0:    cmd_d = full;
                            2'h1:    dat_d[15:8] = full;
                            2'h2:    dat_d[7:0] = full;
                            default: ;
                        endcase
                    end
                    default: ;
                endcase
            end else if (bitcnt_q == 4'h8) begin
                bitcnt_d = 4'h0;
                ack_d = 1'b0;
                case (phase_q)
                    scm_pkg::SCM_ADDR: begin
                        phase_d = rw_q ? scm_pkg::SCM_RD : scm_pkg::SCM_WR;
                        rdidx_d = 2'h0;
                    end
                    scm_pkg::SCM_WR: begin
                        if (bidx_q != 2'h3) bidx_d = bidx_q + 2'h1;
                    end
                    scm_pkg::SCM_RD: begin
                        if (bit_in) phase_d = scm_pkg::SCM_IDLE;
                        else if (rdidx_q != 2'h3) rdidx_d = rdidx_q + 2'h1;
                    end
                    default: ;
                endcase
            end
        end
        if (fall && !start) begin
            drive_d = 1'b0;
            if (ack_q && bitcnt_q == 4'h8) drive_d = 1'b1;
            if (phase_q == scm_pkg::SCM_RD && bitcnt_q < 4'h8) begin
                drive_d = ~txb[~bitcnt_q[2:0]];
            end
        end
    end

    always_comb begin
        mem_we = do_write;
        cmd_mode_d = cmd_mode_q;
        rdata_d = rdata_q;
        resp_ack_d = resp_ack_q;
        active_addr_d = active_addr_q;
        measure_d = 1'b0;
        // R01: power-on window count
        win_open_d = win_open_q && (win_cnt_q < TW'(WIN_CYC - 1));
        win_cnt_d = win_open_q ? win_cnt_q + TW'(1) : win_cnt_q;
        busy_d = busy_q && (busy_cnt_q > TW'(1));
        busy_cnt_d = busy_q ? busy_cnt_q - TW'(1) : busy_cnt_q;
        if (do_enter || do_read || do_rev) begin
            busy_d = 1'b1;
            busy_cnt_d = TW'(RESP_CYC);
            // R07: positive acknowledge once done
            resp_ack_d = `SCM_ACK_POS;
        end
        // R02: entry
        if (do_enter) cmd_mode_d = 1'b1;
        // R03: config word read
        if (do_read) rdata_d = mem_rd;
        // R06: revision read
        if (do_rev) rdata_d = REVISION;
        // R04: config write busy
        if (do_write) begin
            busy_d = 1'b1;
            busy_cnt_d = TW'(WR_CYC);
            resp_ack_d = `SCM_ACK_POS;
        end
        // R05: leave command mode
        if (do_exit) begin
            cmd_mode_d = 1'b0;
            measure_d = 1'b1;
            resp_ack_d = `SCM_ACK_POS;
            // R17: new address applies only now
            active_addr_d = mem_q[`SCM_WORD_ADDR][6:0];
        end
        if (stop && phase_q == scm_pkg::SCM_WR && bidx_q == 2'h3 && !busy_q
            && cmd_mode_q && !(do_read || do_write || do_exit || do_rev)) begin
            resp_ack_d = `SCM_ACK_NEG;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            phase_q <= scm_pkg::SCM_IDLE;
            bitcnt_q <= 4'h0;
            byte_q <= 8'h00;
            bidx_q <= 2'h0;
            rdidx_q <= 2'h0;
            rptr_q <= 4'h0;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            drive_q <= 1'b0;
            cmd_q <= 8'h00;
            dat_q <= 16'h0000;
            // R12: power cycle returns to normal mode
            cmd_mode_q <= 1'b0;
            win_cnt_q <= '0;
            win_open_q <= 1'b1;
            busy_q <= 1'b0;
            busy_cnt_q <= '0;
            resp_ack_q <= `SCM_ACK_BUSY;
            stat_snap_q <= 8'h00;
            rdata_q <= 16'h0000;
            active_addr_q <= ADDR_DEF[6:0];
            measure_q <= 1'b0;
            sda_lo_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            bitcnt_q <= bitcnt_d;
            byte_q <= byte_d;
            bidx_q <= bidx_d;
            rdidx_q <= rdidx_d;
            rptr_q <= rptr_d;
            ack_q <= ack_d;
            rw_q <= rw_d;
            drive_q <= drive_d;
            cmd_q <= cmd_d;
            dat_q <= dat_d;
            cmd_mode_q <= cmd_mode_d;
            win_cnt_q <= win_cnt_d;
            win_open_q <= win_open_d;
            busy_q <= busy_d;
            busy_cnt_q <= busy_cnt_d;
            resp_ack_q <= resp_ack_d;
            stat_snap_q <= stat_snap_d;
            rdata_q <= rdata_d;
            active_addr_q <= active_addr_d;
            measure_q <= measure_d;
            sda_lo_q <= 1'b0;
        end
    end

    // R09: address word reset value; R10: written by code 5C like any word
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            for (int i = 0; i < 32; i++) begin
                mem_q[i] <= (5'(i) == `SCM_WORD_ADDR) ? ADDR_DEF : 16'h0000;
            end
        end else if (mem_we) begin
            mem_q[cmd_q[4:0]] <= dat_q;
        end
    end

    assign o_sda_o = sda_lo_q;
    assign o_sda_oe = drive_q;
    assign o_cmd_mode = cmd_mode_q;
    assign o_window_open = win_open_q;
    assign o_measure_start = measure_q;
    assign o_bus_addr = active_addr_q;

    sequence s_exit_pulse;
        !cmd_mode_q && measure_q ##1 !measure_q;
    endsequence

    sequence s_busy_run;
        busy_q [*8];
    endsequence

    enter_window_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R02
        $rose(cmd_mode_q) |-> $past(win_open_q))
        else $error("command mode entered outside window");
    read_word_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R03
        do_read |=> rdata_q == $past(mem_rd))
        else $error("read command returned wrong word");
    write_busy_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R04
        do_write |=> busy_cnt_q == TW'(WR_CYC) ##0 s_busy_run)
        else $error("write busy time wrong");
    exit_mode_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R05
        do_exit |=> s_exit_pulse)
        else $error("exit did not end command mode");
    rev_word_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R06
        do_rev |=> rdata_q == REVISION)
        else $error("revision word wrong");
    enter_ack_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R07
        $fell(busy_q) && cmd_mode_q && resp_ack_q == `SCM_ACK_POS
        |-> stat_now == 8'h81)
        else $error("positive status byte not 0x81");
    addr_reset_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R09
        $past(i_rst) |-> active_addr_q == 7'h28)
        else $error("address after reset not default");
    resp_time_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R15
        do_read |=> busy_q ##[1:1000] !busy_q)
        else $error("read answer later than allowed");
    status_pack_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R16
        busy_q |-> stat_now[1:0] == `SCM_ACK_BUSY && stat_now[5:2] == 4'h0)
        else $error("status byte fields wrong while busy");
    addr_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R17
        $changed(active_addr_q) |-> $fell(cmd_mode_q))
        else $error("address changed inside command mode");
endmodule

// ===== pkg/scm_map.svh
/*
 * Constants of the command-mode interpreter: command codes, config word
 * index, reset value of the address word, status field codes and times.
 * Assumes inclusion by bare name from the package search path.
 */
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH

`define SCM_CMD_ENTER    8'hA0
`define SCM_CMD_EXIT     8'h80
`define SCM_CMD_REV      8'hB0
`define SCM_GRP_READ     3'h0
`define SCM_GRP_WRITE    3'h2
`define SCM_WORD_ADDR    5'h1C
`define SCM_ADDR_DEFAULT 16'h0028
`define SCM_STAT_CMD     2'h2
`define SCM_STAT_NORM    2'h0
`define SCM_ACK_BUSY     2'h0
`define SCM_ACK_POS      2'h1
`define SCM_ACK_NEG      2'h2
`define SCM_FILL_BYTE    8'hFF
`define SCM_CLK_HZ       10000000
`define SCM_WIN_MS       10
`define SCM_WR_MS        12
`define SCM_RESP_US      100

`endif

// ===== pkg/scm_pkg.sv
/*
 * Types of the command-mode interpreter.
 * Assumes nothing of its surroundings.
 */
package scm_pkg;
    typedef enum logic [3:0] {
        SCM_IDLE = 4'h1,
        SCM_ADDR = 4'h2,
        SCM_WR   = 4'h4,
        SCM_RD   = 4'h8
    } scm_phase_t;
endpackage

// ===== tb/scm_host_model.sv
/*
 * Bus controller model that drives frames at the command-mode target.
 * Assumes the bench resolves the pulled-up data line from both enables.
 */
`timescale 1ns/1ps
module scm_host_model #(
    parameter int QTR_NS = 510
) (
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oe
);
    // clock stands high between frames
    initial begin
        o_scl    = 1'b1;
        o_sda_oe = 1'b0;
    end

    // data moves mid-low, sampled mid-high; b high releases the line
    task automatic bit_io(input logic b, output logic s);
        #(QTR_NS);
        o_sda_oe = ~b;
        #(QTR_NS);
        o_scl = 1'b1;
        #(QTR_NS);
        s = i_sda;
        #(QTR_NS);
        o_scl = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] tx, input logic last,
                        output logic [7:0] rx, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], s);
            rx[i] = s;
        end
        bit_io(last, s);
        ack = ~s;
    endtask

    task automatic start();
        o_sda_oe = 1'b1;
        #(QTR_NS);
        o_scl = 1'b0;
    endtask

    task automatic stop();
        #(QTR_NS);
        o_sda_oe = 1'b1;
        #(QTR_NS);
        o_scl = 1'b1;
        #(QTR_NS);
        o_sda_oe = 1'b0;
        #(QTR_NS);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] c,
                      input logic [15:0] d, output logic ok);
        logic [31:0] f;
        logic [7:0]  rx;
        logic        k;
        f  = {a, 1'b0, c, d};
        ok = 1'b1;
        start();
        for (int i = 0; i < 4; i++) begin
            xfer(f[31-8*i -: 8], 1'b1, rx, k);
            ok = ok & k;
        end
        stop();
    endtask

    task automatic rd(input logic [6:0] a, output logic [23:0] v,
                      output logic ok);
        logic [7:0] rx;
        logic       k;
        v = 24'h000000;
        start();
        xfer({a, 1'b1}, 1'b1, rx, ok);
        for (int i = 0; i < 3 && ok; i++) begin
            xfer(8'hFF, i == 2, rx, k);
            v = {v[15:0], rx};
        end
        stop();
    endtask
endmodule

// ===== tb/tb_top.sv
/*
 * Testbench of the command-mode target: reference memory and scenarios.
 * Assumes the design and the bus controller model compiled before it.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int          WIN = 2000;
    localparam int          WRC = 500;
    localparam int          RSP = 1000;
    // value is arbitrary
    localparam logic [15:0] REV = 16'h0001;

    logic        clk, rst, scl, host_oe, sda_o, sda_oe;
    logic        cmd_mode, win, mstart, ok;
    logic [6:0]  addr, ba;
    logic [15:0] lfsr, dv;
    logic [23:0] v;
    int          mismatches, compares, pulses;
    int          mem [32];
    wire         sda;

    // pulled up: low while either party pulls
    assign sda = ~(host_oe | sda_oe);

    scm_cmd_target #(.WIN_CYC(WIN), .WR_CYC(WRC), .REVISION(REV)) dut (
        .i_sys_clk      (clk),
        .i_rst          (rst),
        .i_scl          (scl),
        .i_sda          (sda),
        .o_sda_o        (sda_o),
        .o_sda_oe       (sda_oe),
        .o_cmd_mode     (cmd_mode),
        .o_window_open  (win),
        .o_measure_start(mstart),
        .o_bus_addr     (addr)
    );

    scm_host_model host (.i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (mstart === 1'b1) pulses++;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic power_up();
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        ba = 7'h28;
        foreach (mem[i]) mem[i] = 0;
        mem[28] = 'h28;
    endtask

    task automatic send(input logic [7:0] c, input logic [15:0] d);
        cyc(1);
        host.wr(ba, c, d, ok);
        check("write_ack", ok, 1'b1);
        if (c[7:5] == 3'h2) mem[c[4:0]] = d;
    endtask

    task automatic fetch();
        cyc(1);
        host.rd(ba, v, ok);
        check("read_ack", ok, 1'b1);
    endtask

    task automatic query(input string what, input logic [7:0] c,
                         input logic [15:0] d, input int w,
                         input logic [23:0] e, input int n);
        send(c, d);
        fetch();
        check({what, "_busy"}, v[23:16], 8'h80);
        cyc(w);
        fetch();
        check(what, v >> (24 - 8*n), e >> (24 - 8*n));
        $display("test %s done", what);
    endtask

    initial begin
        mismatches = 0;
        compares = 0;
        pulses = 0;
        lfsr = 16'h1D69;
        power_up();
        check("window", win, 1'b1);
        check("cmd_mode", cmd_mode, 1'b0);
        check("bus_addr", addr, 7'h28);
        check("sda_o", sda_o, 1'b0);
        cyc(3);
        query("enter", 8'hA0, 16'h0000, RSP, 24'h810000, 1);
        check("cmd_mode", cmd_mode, 1'b1);
        query("rd_addr", 8'h1C, 16'h0000, RSP,
              {8'h81, 16'(mem[28])}, 3);
        for (int i = 0; i < 2; i++) begin
            lfsr = lfsr_next(lfsr);
            dv = lfsr;
            query("wr", i ? 8'h5F : 8'h40, dv, WRC, 24'h810000, 1);
            query("rd_word", i ? 8'h1F : 8'h00, 16'h0000, RSP,
                  {8'h81, 16'(mem[i ? 31 : 0])}, 3);
        end
        query("rev", 8'hB0, 16'h0000, RSP, {8'h81, REV}, 3);
        send(8'h1C, 16'h0001);
        cyc(RSP);
        fetch();
        check("bad_cmd", v[23:16], 8'h82);
        query("new_addr", 8'h5C, 16'h0031, WRC, 24'h810000, 1);
        check("old_addr", addr, 7'h28);
        query("verify", 8'h1C, 16'h0000, RSP,
              {8'h81, 16'(mem[28])}, 3);
        send(8'h80, 16'h0000);
        cyc(2);
        check("pulses", 24'(pulses), 24'h000001);
        check("cmd_mode", cmd_mode, 1'b0);
        check("bus_addr", addr, 7'h31);
        host.rd(7'h28, v, ok);
        check("old_nack", ok, 1'b0);
        ba = 7'h31;
        fetch();
        check("normal_status", v[23:16], 8'h01);
        $display("test exit done");
        cyc(1);
        power_up();
        check("bus_addr", addr, 7'h28);
        cyc(WIN + 10);
        check("window", win, 1'b0);
        send(8'hA0, 16'h0000);
        cyc(2);
        check("late_enter", cmd_mode, 1'b0);
        $display("test late entry done");
        results();
    end

    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        $display("mismatch timeout expected done seen running");
        results();
    end
endmodule
